// *** rtl/pws_pkg.sv ***
package pws_pkg;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned SHORT_HOLD_S = 4;
    localparam int unsigned LONG_HOLD_S = 6;
    localparam int unsigned DEBOUNCE_US = 20;
    localparam int unsigned SHORT_HOLD_CYC = SHORT_HOLD_S * CLK_HZ;
    localparam int unsigned LONG_HOLD_CYC = LONG_HOLD_S * CLK_HZ;
    localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1_000_000);

    // ----------------------------------------
    // power states
    // ----------------------------------------
    typedef enum logic [2:0]
    {
        PWS_S0,
        PWS_S1,
        PWS_S3,
        PWS_S4,
        PWS_S5
    } pws_state_e;

    // ----------------------------------------
    // wake sources
    // ----------------------------------------
    typedef struct packed
    {
        logic lan;
        logic pme;
        logic pcie_wake;
        logic rtc_alarm;
        logic usb;
        logic cir;
    } pws_wake_s;

    // ----------------------------------------
    // wake configuration
    // ----------------------------------------
    typedef struct packed
    {
        logic lan_pme_s5_en;
        logic cir_s4_en;
        logic cir_s5_en;
    } pws_cfg_s;

endpackage

// *** rtl/pws_debounce.sv ***
`timescale 1ns/10ps

module pws_debounce #(
    parameter int unsigned STABLE_CYC = pws_pkg::DEBOUNCE_CYC
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // raw and filtered switch
    input wire logic raw,
    output logic clean
);

    localparam int CW = $clog2(STABLE_CYC + 1);

    initial
    begin
        if (STABLE_CYC < 1)
            $error("debounce count must be at least one");
    end

    logic [CW-1:0] count;
    wire differs = raw != clean;
    wire settled = count == CW'(STABLE_CYC - 1);

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            count <= '0;
        else if (!differs || settled)
            count <= '0;
        else
            count <= count + CW'(1);
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            clean <= 1'b0;
        else if (differs && settled)
            clean <= raw;
    end

endmodule

// *** rtl/pws_sequencer.sv ***
`timescale 1ns/10ps

// Notes on behaviour
// - short press: off to on, on to sleep, sleep to on
// - hold over six seconds forces soft off
// - switch, alarm, pcie wake from all sleeps; usb S1/S3
// - lan and pme wake S1-S4; S5 only if enabled
// - infrared wakes S1/S3; S4/S5 optional by config
// - fans on only in S0 or S1
module pws_sequencer #(
    parameter int unsigned SHORT_CYC = pws_pkg::SHORT_HOLD_CYC,
    parameter int unsigned LONG_CYC = pws_pkg::LONG_HOLD_CYC,
    parameter int unsigned DEB_CYC = pws_pkg::DEBOUNCE_CYC,
    parameter int unsigned CW = 28
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // front panel switch, high while pressed
    input wire logic switch_pressed,
    // wake sources and configuration
    input wire pws_pkg::pws_wake_s wake,
    input wire pws_pkg::pws_cfg_s cfg,
    // sleep request from the operating system
    input wire logic sleep_req,
    input wire pws_pkg::pws_state_e sleep_target,
    // state and outputs
    output pws_pkg::pws_state_e state,
    output logic fan_en,
    output logic wake_event
);

    initial
    begin
        if (SHORT_CYC < 1 || LONG_CYC <= SHORT_CYC || LONG_CYC >= (64'd1 << CW))
            $error("hold counts do not fit");
    end

    // ----------------------------------------
    // switch filter and hold counter
    // ----------------------------------------
    logic sw_clean;
    logic sw_prev;
    logic [CW-1:0] hold;
    logic forced;

    pws_debounce #(
        .STABLE_CYC(DEB_CYC)
    ) u_deb (
        .clk(clk),
        .reset(reset),
        .raw(switch_pressed),
        .clean(sw_clean)
    );

    wire released = sw_prev && !sw_clean;
    wire long_hit = sw_clean && hold == CW'(LONG_CYC);
    wire short_release = released && !forced;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            sw_prev <= 1'b0;
        else
            sw_prev <= sw_clean;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            hold <= '0;
        else if (!sw_clean)
            hold <= '0;
        else if (hold != CW'(LONG_CYC))
            hold <= hold + CW'(1);
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            forced <= 1'b0;
        else if (long_hit)
            forced <= 1'b1;
        else if (!sw_clean)
            forced <= 1'b0;
    end

    // ----------------------------------------
    // wake qualification
    // ----------------------------------------
    wire in_s1s3 = state == pws_pkg::PWS_S1 || state == pws_pkg::PWS_S3;
    wire in_s4 = state == pws_pkg::PWS_S4;
    wire in_s5 = state == pws_pkg::PWS_S5;
    wire sleeping = in_s1s3 || in_s4 || in_s5;
    wire any_state_src = wake.rtc_alarm || wake.pcie_wake;
    wire usb_ok = wake.usb && in_s1s3;
    wire lan_pme = wake.lan || wake.pme;
    wire lan_ok = lan_pme && (in_s1s3 || in_s4 || (in_s5 && cfg.lan_pme_s5_en));
    wire cir_ok = wake.cir && (in_s1s3 || (in_s4 && cfg.cir_s4_en)
        || (in_s5 && cfg.cir_s5_en));
    wire src_wake = sleeping && (any_state_src || usb_ok || lan_ok || cir_ok);

    // ----------------------------------------
    // state sequencing
    // ----------------------------------------
    pws_pkg::pws_state_e next_state;

    always_comb
    begin
        next_state = state;
        if (long_hit && state != pws_pkg::PWS_S5)
            next_state = pws_pkg::PWS_S5;
        else if (short_release)
        begin
            if (state == pws_pkg::PWS_S0)
                next_state = pws_pkg::PWS_S1;
            else
                next_state = pws_pkg::PWS_S0;
        end
        else if (src_wake)
            next_state = pws_pkg::PWS_S0;
        else if (sleep_req && state == pws_pkg::PWS_S0 && sleep_target != pws_pkg::PWS_S0)
            next_state = sleep_target;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            state <= pws_pkg::PWS_S5;
        else
            state <= next_state;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            fan_en <= 1'b0;
        else
            fan_en <= next_state == pws_pkg::PWS_S0 || next_state == pws_pkg::PWS_S1;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            wake_event <= 1'b0;
        else
            wake_event <= sleeping && next_state == pws_pkg::PWS_S0;
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_short_on: assert property (@(posedge clk) disable iff (reset)
        (short_release && !long_hit && state == pws_pkg::PWS_S5) |=> state == pws_pkg::PWS_S0)
        else $error("short press did not power on");
    a_short_sleep: assert property (@(posedge clk) disable iff (reset)
        (short_release && state == pws_pkg::PWS_S0) |=> state == pws_pkg::PWS_S1)
        else $error("short press did not sleep");
    a_long_off: assert property (@(posedge clk) disable iff (reset)
        long_hit |=> state == pws_pkg::PWS_S5)
        else $error("long hold did not force off");
    a_rtc_wake: assert property (@(posedge clk) disable iff (reset)
        (sleeping && wake.rtc_alarm && !long_hit) |=> state == pws_pkg::PWS_S0 && wake_event)
        else $error("alarm did not wake");
    a_usb_deep: assert property (@(posedge clk) disable iff (reset)
        ((in_s4 || in_s5) && !sw_clean && !released && !any_state_src && !lan_pme && !wake.cir)
        |=> state == $past(state))
        else $error("usb woke deep sleep");
    a_lan_s5: assert property (@(posedge clk) disable iff (reset)
        (in_s5 && !cfg.lan_pme_s5_en && lan_pme && !any_state_src && !wake.cir && !released)
        |=> in_s5)
        else $error("lan woke from s5 while disabled");
    a_cir_s4: assert property (@(posedge clk) disable iff (reset)
        (in_s4 && !cfg.cir_s4_en && wake.cir && !any_state_src && !lan_pme && !released)
        |=> in_s4)
        else $error("infrared woke s4 while disabled");
    a_fan_state: assert property (@(posedge clk) disable iff (reset)
        fan_en == (state == pws_pkg::PWS_S0 || state == pws_pkg::PWS_S1))
        else $error("fan enable disagrees with state");
    a_mid_short: assert property (@(posedge clk) disable iff (reset)
        (released && $past(hold) > CW'(SHORT_CYC) && !forced && state == pws_pkg::PWS_S0)
        |=> state == pws_pkg::PWS_S1)
        else $error("mid length press not short");

    // ----------------------------------------
    // wake source, fan, forced release and hold limit checks
    // ----------------------------------------
    a_pcie_wake: assert property (@(posedge clk) disable iff (reset)
        (sleeping && wake.pcie_wake && !long_hit) |=> state == pws_pkg::PWS_S0 && wake_event)
        else $error("pcie wake did not wake");
    a_switch_wake: assert property (@(posedge clk) disable iff (reset)
        (sleeping && short_release) |=> state == pws_pkg::PWS_S0)
        else $error("switch did not wake");
    a_usb_light: assert property (@(posedge clk) disable iff (reset)
        (in_s1s3 && wake.usb && !long_hit) |=> state == pws_pkg::PWS_S0)
        else $error("usb did not wake light sleep");
    a_wake_pulse: assert property (@(posedge clk) disable iff (reset)
        wake_event |-> state == pws_pkg::PWS_S0 && $past(state) != pws_pkg::PWS_S0)
        else $error("wake pulse without a wake");
    a_lan_wake: assert property (@(posedge clk) disable iff (reset)
        ((in_s1s3 || in_s4 || (in_s5 && cfg.lan_pme_s5_en)) && lan_pme && !long_hit)
        |=> state == pws_pkg::PWS_S0)
        else $error("lan or pme did not wake");
    a_cir_light: assert property (@(posedge clk) disable iff (reset)
        (in_s1s3 && wake.cir && !long_hit) |=> state == pws_pkg::PWS_S0)
        else $error("infrared did not wake light sleep");
    a_cir_opt: assert property (@(posedge clk) disable iff (reset)
        (((in_s4 && cfg.cir_s4_en) || (in_s5 && cfg.cir_s5_en)) && wake.cir && !long_hit)
        |=> state == pws_pkg::PWS_S0)
        else $error("enabled infrared did not wake");
    a_cir_s5: assert property (@(posedge clk) disable iff (reset)
        (in_s5 && !cfg.cir_s5_en && wake.cir && !any_state_src && !lan_pme && !released)
        |=> in_s5)
        else $error("infrared woke s5 while disabled");
    a_fan_sleep: assert property (@(posedge clk) disable iff (reset)
        (state == pws_pkg::PWS_S3 || in_s4 || in_s5) |-> !fan_en)
        else $error("fan on in deep state");
    a_forced_release: assert property (@(posedge clk) disable iff (reset)
        (released && forced && in_s5 && !src_wake) |=> in_s5)
        else $error("release after forced off acted");
    a_hold_limit: assert property (@(posedge clk) disable iff (reset)
        hold <= CW'(LONG_CYC))
        else $error("hold counter overran");

endmodule

// *** verif/pws_panel.sv ***
`timescale 1ns/10ps

module pws_panel
(
    // clock
    input wire logic clk,
    // switch and wake lines
    output logic switch_pressed,
    output pws_pkg::pws_wake_s wake
);
    initial
    begin
        switch_pressed = 1'b0;
        wake = '0;
    end

    // hold the switch for a number of cycles
    task automatic press(input int cyc);
        @(negedge clk);
        switch_pressed = 1'b1;
        repeat (cyc) @(negedge clk);
        switch_pressed = 1'b0;
    endtask

    // one-cycle wake request, then released low
    task automatic raise(input int idx);
        @(negedge clk);
        wake[idx] = 1'b1;
        @(negedge clk);
        wake = '0;
    endtask
endmodule

// *** verif/power_switch_wake_sequencer_tb_top.sv ***
`timescale 1ns/10ps

module power_switch_wake_sequencer_tb_top;
    logic clk = 1'b0;
    logic reset;
    logic sleep_req;
    logic switch_pressed;
    pws_pkg::pws_state_e sleep_target;
    pws_pkg::pws_state_e state;
    pws_pkg::pws_cfg_s cfg;
    pws_pkg::pws_wake_s wake;
    logic fan_en;
    logic wake_event;
    int errors = 0;
    int compares = 0;
    int cycles = 0;

    always #20 clk = ~clk;

    pws_panel panel (.clk(clk), .switch_pressed(switch_pressed), .wake(wake));

    pws_sequencer #(.SHORT_CYC(40), .LONG_CYC(60), .DEB_CYC(2)) dut
    (
        .clk(clk),
        .reset(reset),
        .switch_pressed(switch_pressed),
        .wake(wake),
        .cfg(cfg),
        .sleep_req(sleep_req),
        .sleep_target(sleep_target),
        .state(state),
        .fan_en(fan_en),
        .wake_event(wake_event)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic go_sleep(input pws_pkg::pws_state_e t);
        @(negedge clk);
        sleep_req = 1'b1;
        sleep_target = t;
        @(negedge clk);
        sleep_req = 1'b0;
        @(negedge clk);
    endtask

    function automatic logic ok(input int src, input pws_pkg::pws_state_e st);
        logic light;
        light = st == pws_pkg::PWS_S1 || st == pws_pkg::PWS_S3;
        case (src)
            2, 3: return 1'b1;
            1: return light;
            0: return light || (st == pws_pkg::PWS_S4 && cfg.cir_s4_en)
                || (st == pws_pkg::PWS_S5 && cfg.cir_s5_en);
            default: return light || st == pws_pkg::PWS_S4 || cfg.lan_pme_s5_en;
        endcase
    endfunction

    task automatic test_switch;
        check(state, pws_pkg::PWS_S5, "reset state");
        check(fan_en, 1'b0, "fan off");
        panel.press(20);
        repeat (10) @(negedge clk);
        check(state, pws_pkg::PWS_S0, "power on");
        check(fan_en, 1'b1, "fan on");
        panel.press(50);
        repeat (10) @(negedge clk);
        check(state, pws_pkg::PWS_S1, "mid press sleep");
        panel.press(20);
        repeat (10) @(negedge clk);
        check(state, pws_pkg::PWS_S0, "resume");
        panel.press(70);
        repeat (10) @(negedge clk);
        check(state, pws_pkg::PWS_S5, "forced off");
        panel.press(20);
        repeat (10) @(negedge clk);
        check(state, pws_pkg::PWS_S0, "power on again");
        go_sleep(pws_pkg::PWS_S0);
        check(fan_en, 1'b1, "fan on s0 target");
        go_sleep(pws_pkg::PWS_S3);
        panel.press(70);
        repeat (10) @(negedge clk);
        check(state, pws_pkg::PWS_S5, "forced off sleep");
        panel.raise(2);
        check(state, pws_pkg::PWS_S0, "alarm wake");
    endtask

    task automatic test_wake(input pws_pkg::pws_cfg_s c);
        pws_pkg::pws_state_e st;
        logic exp;
        cfg = c;
        for (int s = 1; s <= 4; s++)
        begin
            for (int src = 0; src < 6; src++)
            begin
                st = pws_pkg::pws_state_e'(s);
                exp = ok(src, st);
                go_sleep(st);
                check(fan_en, st == pws_pkg::PWS_S1, "sleep fan");
                panel.raise(src);
                check(state == pws_pkg::PWS_S0, exp, "woken");
                check(wake_event, exp, "wake pulse");
                if (!exp)
                    panel.raise(2);
            end
        end
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            tally_and_finish();
        end
    end

    initial
    begin
        reset = 1'b1;
        sleep_req = 1'b0;
        sleep_target = pws_pkg::PWS_S1;
        cfg = '0;
        repeat (16) @(negedge clk);
        reset = 1'b0;
        test_switch();
        test_wake(3'h0);
        test_wake(3'h7);
        test_wake(3'h5);
        test_wake(3'h2);
        tally_and_finish();
    end
endmodule
